//--- logic/spgc_top.sv
`timescale 1ns/1ps
`include "spgc_defines.svh"
// Behaviour
// - Sixteen pins, each own enable, direction
// - Pin acts as GPIO only when enabled
// - Direction zero: input, never driven
// - Direction one: output, driven
// - Cleared enable overrides direction
// - Direction bits reset to zero
// - Enables reset: pins 7..3 and 0
// - Enable register, upper half reads zero
// - Direction register, upper half reads zero
module spgc_top (
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [31:0] PADDR,
	input  wire logic [31:0] PWDATA,
	input  wire logic [3:0]  PSTRB,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic [15:0] GENERAL_PINS_IN,
	output logic      [15:0] GENERAL_PINS_OUT,
	output logic      [15:0] GENERAL_PINS_OE,
	output logic      [15:0] PIN_INPUT_LEVEL,
	input  wire logic [15:0] PIN_OUTPUT_VALUE
);
	// ****************************************
	// Register state
	// ****************************************
	spgc_pkg::spgc_pins_t pin_enable_bit_q;
	spgc_pkg::spgc_pins_t pin_enable_bit_d;
	spgc_pkg::spgc_pins_t pin_direction_bit_q;
	spgc_pkg::spgc_pins_t pin_direction_bit_d;
	logic [31:0]          prdata_q;
	logic [31:0]          prdata_d;
	logic                 pready_q;
	logic                 pready_d;
	logic                 pslverr_q;
	logic                 pslverr_d;
	spgc_pkg::spgc_pins_t pins_out_q;
	spgc_pkg::spgc_pins_t pins_out_d;
	spgc_pkg::spgc_pins_t pins_oe_q;
	spgc_pkg::spgc_pins_t pins_oe_d;
	spgc_pkg::spgc_pins_t level_q;
	spgc_pkg::spgc_pins_t level_d;
	spgc_pkg::spgc_pins_t pins_sync;
	logic                 hit_enable;
	logic                 hit_direction;
	logic                 setup_phase;
	logic                 access_done;
	logic [15:0]          lane_mask;

	// ****************************************
	// Pin input synchroniser
	// ****************************************
	spgc_sync #(
		.WIDTH (`SPGC_PIN_COUNT)
	) u_sync (
		.CLK      (CLK),
		.RST      (RST),
		.async_in (GENERAL_PINS_IN),
		.sync_out (pins_sync)
	);

	// ****************************************
	// APB slave
	// ****************************************
	// No wait state: the answer is registered in setup, given in the first access cycle
	always_comb begin
		setup_phase   = PSEL && !PENABLE;
		access_done   = PSEL && PENABLE && pready_q;
		hit_enable    = (PADDR == `SPGC_ADDR_ENABLE);
		hit_direction = (PADDR == `SPGC_ADDR_DIRECTION);
		lane_mask     = {{8{PSTRB[1]}}, {8{PSTRB[0]}}};
	end

	always_comb begin
		pin_enable_bit_d    = pin_enable_bit_q;
		pin_direction_bit_d = pin_direction_bit_q;
		prdata_d            = prdata_q;
		pready_d            = 1'b0;
		pslverr_d           = 1'b0;
		if (setup_phase) begin
			pready_d  = 1'b1;
			pslverr_d = !(hit_enable || hit_direction);
			prdata_d  = 32'h00000000;
			if (!PWRITE && hit_enable) begin
				prdata_d = {16'h0000, pin_enable_bit_q};
			end else if (!PWRITE && hit_direction) begin
				prdata_d = {16'h0000, pin_direction_bit_q};
			end
		end
		if (access_done && PWRITE) begin
			// Upper lanes dropped: reserved half is read-only
			if (hit_enable) begin
				pin_enable_bit_d = (pin_enable_bit_q & ~lane_mask) | (PWDATA[15:0] & lane_mask);
			end
			if (hit_direction) begin
				pin_direction_bit_d = (pin_direction_bit_q & ~lane_mask) | (PWDATA[15:0] & lane_mask);
			end
		end
		if (access_done) begin
			prdata_d = 32'h00000000;
		end
	end

	// ****************************************
	// Pin control
	// ****************************************
	always_comb begin
		pins_oe_d  = pin_enable_bit_q & pin_direction_bit_q;
		pins_out_d = PIN_OUTPUT_VALUE & pins_oe_d;
		level_d    = pins_sync & pin_enable_bit_q & ~pin_direction_bit_q;
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			pin_enable_bit_q    <= `SPGC_ENABLE_RESET;
			pin_direction_bit_q <= `SPGC_DIR_RESET;
			prdata_q            <= 32'h00000000;
			pready_q            <= 1'b0;
			pslverr_q           <= 1'b0;
			pins_out_q          <= `SPGC_SYNC_RESET;
			pins_oe_q           <= `SPGC_SYNC_RESET;
			level_q             <= `SPGC_SYNC_RESET;
		end else begin
			pin_enable_bit_q    <= pin_enable_bit_d;
			pin_direction_bit_q <= pin_direction_bit_d;
			prdata_q            <= prdata_d;
			pready_q            <= pready_d;
			pslverr_q           <= pslverr_d;
			pins_out_q          <= pins_out_d;
			pins_oe_q           <= pins_oe_d;
			level_q             <= level_d;
		end
	end

	always_comb begin
		PRDATA           = prdata_q;
		PREADY           = pready_q;
		PSLVERR          = pslverr_q;
		GENERAL_PINS_OUT = pins_out_q;
		GENERAL_PINS_OE  = pins_oe_q;
		PIN_INPUT_LEVEL  = level_q;
	end

	// ****************************************
	// Checks
	// ****************************************
	property p_oe_needs_enable;
		@(posedge CLK) disable iff (RST)
		(GENERAL_PINS_OE & ~pin_enable_bit_q & ~$past(pin_enable_bit_q)) == 16'h0000;
	endproperty
	a_oe_needs_enable: assert property (p_oe_needs_enable)
		else $error("Pin driven while not enabled");

	property p_input_not_driven;
		@(posedge CLK) disable iff (RST)
		$stable(pin_direction_bit_q) && $stable(pin_enable_bit_q) |=>
			(GENERAL_PINS_OE & ~$past(pin_direction_bit_q)) == 16'h0000;
	endproperty
	a_input_not_driven: assert property (p_input_not_driven)
		else $error("Input pin driven");

	property p_output_driven;
		@(posedge CLK) disable iff (RST)
		1'b1 |=> GENERAL_PINS_OE == ($past(pin_enable_bit_q) & $past(pin_direction_bit_q));
	endproperty
	a_output_driven: assert property (p_output_driven)
		else $error("Enabled output pin not driven");

	property p_reset_values;
		@(posedge CLK)
		$past(RST) |-> pin_enable_bit_q == 16'h00F9 && pin_direction_bit_q == 16'h0000;
	endproperty
	a_reset_values: assert property (p_reset_values)
		else $error("Wrong reset value of pin registers");

	property p_dir_reset;
		@(posedge CLK)
		$past(RST) |-> GENERAL_PINS_OE == 16'h0000;
	endproperty
	a_dir_reset: assert property (p_dir_reset)
		else $error("Pin driven right after reset");

	property p_upper_zero;
		@(posedge CLK) disable iff (RST)
		PREADY |-> PRDATA[31:16] == 16'h0000;
	endproperty
	a_upper_zero: assert property (p_upper_zero)
		else $error("Reserved bits read nonzero");

	property p_read_enable;
		@(posedge CLK) disable iff (RST)
		PSEL && !PENABLE && !PWRITE && PADDR == 32'h01B00000 |=> PRDATA[15:0] == $past(pin_enable_bit_q);
	endproperty
	a_read_enable: assert property (p_read_enable)
		else $error("Enable read does not match register");

	property p_write_dir;
		@(posedge CLK) disable iff (RST)
		PSEL && PENABLE && PREADY && PWRITE && PADDR == 32'h01B00004 && PSTRB[1:0] == 2'b11
			|=> pin_direction_bit_q == $past(PWDATA[15:0]);
	endproperty
	a_write_dir: assert property (p_write_dir)
		else $error("Direction write not stored");

	property p_sync_delay;
		@(posedge CLK) disable iff (RST)
		(pin_enable_bit_q[0] && !pin_direction_bit_q[0]) [*4]
			|-> PIN_INPUT_LEVEL[0] == $past(GENERAL_PINS_IN[0], 3);
	endproperty
	a_sync_delay: assert property (p_sync_delay)
		else $error("Input level not three cycles behind pin");

	property p_disabled_quiet;
		@(posedge CLK) disable iff (RST)
		1'b1 |=> (PIN_INPUT_LEVEL & ~$past(pin_enable_bit_q)) == 16'h0000;
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet)
		else $error("Disabled pin shows input level");

	property p_slverr;
		@(posedge CLK) disable iff (RST)
		PSEL && !PENABLE && PADDR != 32'h01B00000 && PADDR != 32'h01B00004 |=> PREADY && PSLVERR;
	endproperty
	a_slverr: assert property (p_slverr)
		else $error("Unmapped address not refused");

	property p_ready_after_setup;
		@(posedge CLK) disable iff (RST)
		PSEL && !PENABLE |=> PREADY;
	endproperty
	a_ready_after_setup: assert property (p_ready_after_setup)
		else $error("No answer in the access cycle");

	property p_ready_one_cycle;
		@(posedge CLK) disable iff (RST)
		PREADY |=> !PREADY;
	endproperty
	a_ready_one_cycle: assert property (p_ready_one_cycle)
		else $error("Ready held past the access cycle");

	property p_data_idle_zero;
		@(posedge CLK) disable iff (RST)
		!PREADY |-> PRDATA == 32'h00000000;
	endproperty
	a_data_idle_zero: assert property (p_data_idle_zero)
		else $error("Read data shown outside an answer");

	property p_read_direction;
		@(posedge CLK) disable iff (RST)
		PSEL && !PENABLE && !PWRITE && PADDR == `SPGC_ADDR_DIRECTION
			|=> PRDATA == {16'h0000, $past(pin_direction_bit_q)};
	endproperty
	a_read_direction: assert property (p_read_direction)
		else $error("Direction read does not match register");

	property p_write_enable;
		@(posedge CLK) disable iff (RST)
		PSEL && PENABLE && PREADY && PWRITE && PADDR == `SPGC_ADDR_ENABLE && PSTRB[1:0] == 2'b11
			|=> pin_enable_bit_q == $past(PWDATA[15:0]);
	endproperty
	a_write_enable: assert property (p_write_enable)
		else $error("Enable write not stored");

	property p_low_lane_only;
		@(posedge CLK) disable iff (RST)
		PSEL && PENABLE && PREADY && PWRITE && PADDR == `SPGC_ADDR_ENABLE && PSTRB[1:0] == 2'b01
			|=> pin_enable_bit_q == {$past(pin_enable_bit_q[15:8]), $past(PWDATA[7:0])};
	endproperty
	a_low_lane_only: assert property (p_low_lane_only)
		else $error("Unstrobed enable byte changed");

	property p_no_stray_write;
		@(posedge CLK) disable iff (RST)
		!(PSEL && PENABLE && PREADY && PWRITE) |=> $stable(pin_enable_bit_q) && $stable(pin_direction_bit_q);
	endproperty
	a_no_stray_write: assert property (p_no_stray_write)
		else $error("Pin register changed without a write");

	property p_unmapped_ignored;
		@(posedge CLK) disable iff (RST)
		PSEL && PENABLE && PREADY && PWRITE && PADDR != `SPGC_ADDR_ENABLE && PADDR != `SPGC_ADDR_DIRECTION
			|=> $stable(pin_enable_bit_q) && $stable(pin_direction_bit_q);
	endproperty
	a_unmapped_ignored: assert property (p_unmapped_ignored)
		else $error("Unmapped write changed a pin register");

	property p_out_value;
		@(posedge CLK) disable iff (RST)
		1'b1 |=> GENERAL_PINS_OUT ==
			($past(PIN_OUTPUT_VALUE) & $past(pin_enable_bit_q) & $past(pin_direction_bit_q));
	endproperty
	a_out_value: assert property (p_out_value)
		else $error("Output pin value wrong");

	property p_output_no_level;
		@(posedge CLK) disable iff (RST)
		1'b1 |=> (PIN_INPUT_LEVEL & $past(pin_direction_bit_q)) == 16'h0000;
	endproperty
	a_output_no_level: assert property (p_output_no_level)
		else $error("Output pin shows input level");
endmodule

//--- logic/spgc_defines.svh
`ifndef SPGC_DEFINES_SVH
`define SPGC_DEFINES_SVH
// Register byte addresses
`define SPGC_ADDR_ENABLE    32'h01B00000
`define SPGC_ADDR_DIRECTION 32'h01B00004
// Pins and field layout
`define SPGC_PIN_COUNT      16
`define SPGC_PIN_MSB        15
// Reset values
`define SPGC_ENABLE_RESET   16'h00F9
`define SPGC_DIR_RESET      16'h0000
`define SPGC_SYNC_RESET     16'h0000
`endif

//--- logic/spgc_pkg.sv
package spgc_pkg;
	typedef logic [15:0] spgc_pins_t;
	typedef enum logic [2:0] {
		SPGC_IDLE   = 3'b001,
		SPGC_ACCESS = 3'b010,
		SPGC_DONE   = 3'b100
	} spgc_bus_e;
endpackage

//--- logic/spgc_sync.sv
`timescale 1ns/1ps
`include "spgc_defines.svh"
// Two-flop synchroniser; first stage read only by second
module spgc_sync #(
	parameter int WIDTH = 16
) (
	input  wire logic             CLK,
	input  wire logic             RST,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] stable_q;
	logic [WIDTH-1:0] stable_d;

	always_comb begin
		meta_d   = async_in;
		stable_d = meta_q;
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			meta_q   <= '0;
			stable_q <= '0;
		end else begin
			meta_q   <= meta_d;
			stable_q <= stable_d;
		end
	end

	assign sync_out = stable_q;
endmodule

//--- verification/tb_sixteen_pin_gpio_control.sv
`timescale 1ns/1ps
`include "spgc_defines.svh"
module tb_sixteen_pin_gpio_control;
	logic        CLK              = 1'b0;
	logic        RST              = 1'b1;
	logic        PSEL             = 1'b0;
	logic        PENABLE          = 1'b0;
	logic        PWRITE           = 1'b0;
	logic [31:0] PADDR            = 32'h0;
	logic [31:0] PWDATA           = 32'h0;
	logic [3:0]  PSTRB            = 4'h0;
	logic [31:0] PRDATA;
	logic        PREADY;
	logic        PSLVERR;
	logic [15:0] GENERAL_PINS_IN  = 16'h0;
	logic [15:0] GENERAL_PINS_OUT;
	logic [15:0] GENERAL_PINS_OE;
	logic [15:0] PIN_INPUT_LEVEL;
	logic [15:0] PIN_OUTPUT_VALUE = 16'h0;
	logic [31:0] rng              = 32'h81C6A7BB;
	logic [31:0] rd;
	logic [31:0] d;
	logic [31:0] r;
	logic [31:0] a;
	logic        err;
	logic [15:0] en_m;
	logic [15:0] dir_m;
	int          fail_count       = 0;
	int          n_compared       = 0;

	spgc_top dut_u (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .GENERAL_PINS_IN(GENERAL_PINS_IN), .GENERAL_PINS_OUT(GENERAL_PINS_OUT),
		.GENERAL_PINS_OE(GENERAL_PINS_OE), .PIN_INPUT_LEVEL(PIN_INPUT_LEVEL),
		.PIN_OUTPUT_VALUE(PIN_OUTPUT_VALUE));

	always #20 CLK = ~CLK;

	// ********************************
	// Helpers
	// ********************************
	function logic [31:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	// Byte lanes 2 and 3 carry only reserved bits
	function logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] s);
		return {s[1] ? wd[15:8] : old[15:8], s[0] ? wd[7:0] : old[7:0]};
	endfunction

	task give_verdict();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Master waits for the answer; the 20-cycle bound ends a wait with no answer
	task apb(input logic wr, input logic [31:0] ad, input logic [31:0] wd, input logic [3:0] s);
		int n;
		@(posedge CLK);
		PSEL    <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE  <= wr;
		PADDR   <= ad;
		PWDATA  <= wd;
		PSTRB   <= s;
		@(posedge CLK);
		PENABLE <= 1'b1;
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (PREADY !== 1'b1 && n < 20);
		if (PREADY !== 1'b1) begin
			fail_count++;
			$display("Error pready timeout");
			give_verdict();
		end else begin
			rd = PRDATA;
			err = PSLVERR;
			PSEL    <= 1'b0;
			PENABLE <= 1'b0;
		end
	endtask

	task pins();
		repeat (4) @(posedge CLK);
		chk("oe", {16'h0, GENERAL_PINS_OE}, {16'h0, en_m & dir_m});
		chk("out", {16'h0, GENERAL_PINS_OUT}, {16'h0, PIN_OUTPUT_VALUE & en_m & dir_m});
		chk("level", {16'h0, PIN_INPUT_LEVEL}, {16'h0, GENERAL_PINS_IN & en_m & ~dir_m});
	endtask

	// ********************************
	// Main sequence
	// ********************************
	initial begin
		repeat (8) @(posedge CLK);
		RST <= 1'b0;
		GENERAL_PINS_IN <= 16'hA5C3;
		apb(1'b0, `SPGC_ADDR_ENABLE, 32'h0, 4'h0);
		chk("enable reset", rd, 32'h000000F9);
		chk("enable err", {31'h0, err}, 32'h0);
		apb(1'b0, `SPGC_ADDR_DIRECTION, 32'h0, 4'h0);
		chk("direction reset", rd, 32'h0);
		en_m = 16'h00F9;
		dir_m = 16'h0000;
		pins();
		$display("reset test done");
		for (int i = 0; i < 40; i++) begin
			r = xs();
			d = (i < 2) ? {32{i[0]}} : xs();
			a = r[4] ? `SPGC_ADDR_DIRECTION : `SPGC_ADDR_ENABLE;
			if (i < 4)
				r[3:0] = 4'hF;
			apb(1'b1, a, d, r[3:0]);
			if (r[4])
				dir_m = merge(dir_m, d, r[3:0]);
			else
				en_m = merge(en_m, d, r[3:0]);
			GENERAL_PINS_IN <= 16'(xs());
			PIN_OUTPUT_VALUE <= 16'(xs());
			apb(1'b0, a, 32'h0, 4'h0);
			chk("readback", rd, {16'h0, r[4] ? dir_m : en_m});
			chk("err", {31'h0, err}, 32'h0);
			pins();
		end
		$display("random test done");
		// Mid-run reset must restore both registers
		RST <= 1'b1;
		repeat (3) @(posedge CLK);
		RST <= 1'b0;
		apb(1'b0, `SPGC_ADDR_ENABLE, 32'h0, 4'h0);
		chk("enable rerun", rd, 32'h000000F9);
		apb(1'b0, `SPGC_ADDR_DIRECTION, 32'h0, 4'h0);
		chk("direction rerun", rd, 32'h0);
		en_m = 16'h00F9;
		dir_m = 16'h0000;
		pins();
		$display("mid-run reset test done");
		for (int i = 0; i < 3; i++) begin
			a = (i == 0) ? `SPGC_ADDR_ENABLE + 32'h8 : (i == 1) ? 32'h01B10000 : `SPGC_ADDR_ENABLE - 32'h4;
			apb(1'b1, a, 32'hFFFFFFFF, 4'hF);
			chk("unmapped werr", {31'h0, err}, 32'h1);
			apb(1'b0, a, 32'h0, 4'h0);
			chk("unmapped rerr", {31'h0, err}, 32'h1);
			chk("unmapped data", rd, 32'h0);
		end
		apb(1'b0, `SPGC_ADDR_ENABLE, 32'h0, 4'h0);
		chk("enable kept", rd, {16'h0, en_m});
		$display("unmapped test done");
		give_verdict();
	end
endmodule
